// File: include/elevator_pkg.sv
// Types shared by the elevator mode supervisor and its timers.
`include "elevator_regs.svh"

package elevator_pkg;

  typedef enum logic [`STATE_W-1:0] {
    NORMAL      = 10'h001,
    RESCUE      = 10'h002,
    PARK_RUN    = 10'h004,
    PARKED      = 10'h008,
    FIRE_STOP   = 10'h010,
    FIRE_RET    = 10'h020,
    FIRE_HOLD   = 10'h040,
    FIRE_CLOSE  = 10'h080,
    FIRE_RUN    = 10'h100,
    FIRE_ARRIVE = 10'h200
  } mode_t;

  // Everything arriving from the car, landings and the peer controller.
  typedef struct packed {
    logic                fire_sw;
    logic                fire_mode;
    logic                park_key;
    logic                inspection;
    logic                moving;
    logic                dir_up;
    logic                at_level;
    logic                door_closed;
    logic                door_open_full;
    logic                open_btn;
    logic                close_btn;
    logic                fault_stop;
    logic                safety_ok;
    logic                inv_ok;
    logic                car_btn;
    logic                landing_btn;
    logic                peer_idle;
    logic [`FLOOR_W-1:0] car_floor;
    logic [`FLOOR_W-1:0] car_btn_floor;
    logic [`FLOOR_W-1:0] landing_btn_floor;
    logic [`COST_W-1:0]  peer_cost;
  } pins_t;

  typedef struct packed {
    logic [`TMR_W-1:0] cnt;
    logic              expired;
  } timer_t;

  function automatic logic in_fire(input mode_t m);
    in_fire = (m == FIRE_STOP) || (m == FIRE_RET) || (m == FIRE_HOLD) ||
              (m == FIRE_CLOSE) || (m == FIRE_RUN) || (m == FIRE_ARRIVE);
  endfunction : in_fire

endpackage : elevator_pkg

// File: include/elevator_regs.svh
// Widths, reset values and timing counts of the elevator mode supervisor.
`ifndef ELEVATOR_REGS_SVH
`define ELEVATOR_REGS_SVH

`define FLOOR_W        5
`define FLOORS         32
`define COST_W         6
`define CAR_IDX_W      3
`define MAX_CARS       8
`define STATE_W        10

`define CLK_PERIOD_NS  10
`define TICK_NS        1000000
`define TICK_CYCLES    (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_W         17
`define TICKS_PER_S    1000
`define IDLE_MIN       15
`define IDLE_TICKS     (`IDLE_MIN * 60 * `TICKS_PER_S)
`define PARK_S         10
`define PARK_TICKS     (`PARK_S * `TICKS_PER_S)
`define TMR_W          20

`define FIRE_MODE_HALT 1'b1
`define LIGHT_RST      1'b1
`define DISPLAY_RST    1'b1

`endif

// File: logic/elevator_mode_supervisor.sv
// Supervisory modes of the elevator controller: light, fire, rescue, parking.
// Operation
// - Car light goes off after 15 idle minutes, back on at any call.
// - Fire switch enters fire mode, cancels all calls, returns to fire floor.
// - Back at fire floor door held open; fire linkage only after return.
// - Travelling away: stop at nearest floor, door shut, then go.
// - Fire mode 1 halts all movement once at the fire floor.
// - Fire mode 0 ignores landing calls and holds door open at fire floor.
// - Close button released early reopens the door, no run.
// - At destination door opens only while open button held to full.
// - Fire mode 0 accepts one destination per run.
// - Fault outside landing zone: crawl toward middle to level, open door.
// - Rescue crawl only with safety circuit and inverter healthy.
// - Key lock enters parking: no landing calls, serve car calls, go park.
// - At park floor show parking indication, ignore all calls.
// - Ten seconds after parking close door, light and displays off.
// - Parked: car button or door button turns the light on.
// - Parking under inspection skips car call runs and auto return, keeps the rest.
// - Stays working while parked, normal as soon as key opens.
// - Duplex: each landing call costed by both, answered by one.
// - Duplex both idle: lead car goes to waiting floor, other stays.
// - Group control of up to 8 cars.
`timescale 1ns/1ps
`include "elevator_regs.svh"

module elevator_mode_supervisor #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int IDLE_TICKS  = `IDLE_TICKS,
  parameter int PARK_TICKS  = `PARK_TICKS
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  fire_sw,
  input  wire logic                  fire_mode,
  input  wire logic                  park_key,
  input  wire logic                  inspection,
  input  wire logic                  moving,
  input  wire logic                  dir_up,
  input  wire logic                  at_level,
  input  wire logic                  door_closed,
  input  wire logic                  door_open_full,
  input  wire logic                  open_btn,
  input  wire logic                  close_btn,
  input  wire logic                  fault_stop,
  input  wire logic                  safety_ok,
  input  wire logic                  inv_ok,
  input  wire logic                  car_btn,
  input  wire logic [`FLOOR_W-1:0]   car_btn_floor,
  input  wire logic                  landing_btn,
  input  wire logic [`FLOOR_W-1:0]   landing_btn_floor,
  input  wire logic [`FLOOR_W-1:0]   car_floor,
  input  wire logic                  peer_idle,
  input  wire logic [`COST_W-1:0]    peer_cost,
  input  wire logic [`FLOOR_W-1:0]   fire_floor,
  input  wire logic [`FLOOR_W-1:0]   park_floor,
  input  wire logic [`FLOOR_W-1:0]   wait_floor,
  input  wire logic [`FLOOR_W-1:0]   middle_floor,
  input  wire logic                  duplex_en,
  input  wire logic                  duplex_lead,
  input  wire logic                  group_en,
  input  wire logic [`CAR_IDX_W-1:0] car_index,
  input  wire logic [`MAX_CARS-1:0]  group_assign,
  output logic [`FLOOR_W-1:0]        target_floor,
  output logic                       run_req,
  output logic                       stop_next,
  output logic                       crawl_en,
  output logic                       crawl_up,
  output logic                       door_open_cmd,
  output logic                       door_close_cmd,
  output logic                       fire_link,
  output logic                       parking_ind,
  output logic                       display_on,
  output logic                       car_light,
  output logic                       cancel_calls,
  output logic                       landing_accept,
  output logic [`FLOORS-1:0]         car_calls,
  output logic [`FLOORS-1:0]         landing_calls,
  output logic [`COST_W-1:0]         my_cost,
  output logic                       car_idle,
  output logic                       normal_mode
);

  typedef struct packed {
    elevator_pkg::pins_t  s1;
    elevator_pkg::pins_t  s2;
    elevator_pkg::pins_t  p;
    elevator_pkg::mode_t  mode;
    logic [`TICK_W-1:0]   tick_cnt;
    logic [`FLOORS-1:0]   car_calls;
    logic [`FLOORS-1:0]   landing_calls;
    logic                 dest_valid;
    logic [`FLOOR_W-1:0]  dest;
    logic [`FLOOR_W-1:0]  target;
    logic                 run_req;
    logic                 stop_next;
    logic                 crawl_en;
    logic                 crawl_up;
    logic                 door_open;
    logic                 door_close;
    logic                 fire_link;
    logic                 parking_ind;
    logic                 display_on;
    logic                 car_light;
    logic                 cancel_calls;
    logic                 landing_accept;
    logic [`COST_W-1:0]   my_cost;
    logic                 car_idle;
  } state_t;

  state_t q, d;
  elevator_pkg::pins_t pins;
  elevator_pkg::pins_t s;
  elevator_pkg::pins_t p;

  logic tick, idle_exp, park_exp, idle_restart, park_restart;
  logic car_press, land_press, door_press, stopped, away, rescue_go;
  logic land_ok, any_car;
  logic [`FLOOR_W-1:0] first_car;

  assign pins = '{fire_sw, fire_mode, park_key, inspection, moving, dir_up,
                  at_level, door_closed, door_open_full, open_btn, close_btn,
                  fault_stop, safety_ok, inv_ok, car_btn, landing_btn,
                  peer_idle, car_floor, car_btn_floor, landing_btn_floor,
                  peer_cost};

  function automatic logic [`FLOOR_W-1:0] lowest(input logic [`FLOORS-1:0] v);
    lowest = '0;
    for (int i = `FLOORS - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = `FLOOR_W'(i);
      end
    end
  endfunction : lowest

  ////////////////////////////////////////////////////////////////////////////
  // Time base and timeouts.

  assign tick = (q.tick_cnt == `TICK_W'(TICK_CYCLES - 1));

  timeout_timer #(.LIMIT(IDLE_TICKS)) u_idle_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .tick    (tick),
    .restart (idle_restart),
    .expired (idle_exp)
  );

  timeout_timer #(.LIMIT(PARK_TICKS)) u_park_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .tick    (tick),
    .restart (park_restart),
    .expired (park_exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode logic. Pins are read only after the second synchroniser stage.

  assign s          = q.s2;
  assign p          = q.p;
  assign car_press  = s.car_btn & ~p.car_btn;
  assign land_press = s.landing_btn & ~p.landing_btn;
  assign door_press = (s.open_btn & ~p.open_btn) | (s.close_btn & ~p.close_btn);
  assign stopped    = s.at_level & ~s.moving;
  assign away       = s.moving & (s.dir_up ? (fire_floor < s.car_floor)
                                           : (fire_floor > s.car_floor));
  assign rescue_go  = s.fault_stop & ~s.at_level;
  assign any_car    = |q.car_calls;
  assign first_car  = lowest(q.car_calls);
  // Group assignment wins over duplex costing; a cost tie goes to the lead.
  assign land_ok    = group_en ? group_assign[car_index] :
                      duplex_en ? ((q.my_cost < s.peer_cost) ||
                                   ((q.my_cost == s.peer_cost) && duplex_lead))
                                : 1'b1;
  // Any call or movement keeps the light timer fresh.
  assign idle_restart = car_press | land_press | door_press | s.moving |
                        (q.mode != elevator_pkg::NORMAL);
  assign park_restart = ((q.mode == elevator_pkg::PARK_RUN) &&
                         (d.mode == elevator_pkg::PARKED)) ||
                        ((q.mode == elevator_pkg::PARKED) &&
                         (car_press || door_press));

  always_comb begin
    d                = q;
    d.s1             = pins;
    d.s2             = q.s1;
    d.p              = q.s2;
    d.tick_cnt       = tick ? '0 : q.tick_cnt + `TICK_W'(1);
    d.my_cost        = `COST_W'((s.car_floor > s.landing_btn_floor) ?
                                (s.car_floor - s.landing_btn_floor) :
                                (s.landing_btn_floor - s.car_floor)) +
                       `COST_W'(s.moving);
    d.car_idle       = ~any_car & ~(|q.landing_calls) & ~s.moving;
    d.run_req        = 1'b0;
    d.stop_next      = 1'b0;
    d.crawl_en       = 1'b0;
    d.crawl_up       = 1'b0;
    d.door_open      = 1'b0;
    d.door_close     = 1'b0;
    d.parking_ind    = 1'b0;
    d.display_on     = 1'b1;
    d.cancel_calls   = 1'b0;
    d.landing_accept = 1'b0;
    d.car_light      = ~idle_exp | car_press | land_press;
    if (s.fire_sw && !elevator_pkg::in_fire(q.mode)) begin
      d.cancel_calls  = 1'b1;
      d.car_calls     = '0;
      d.landing_calls = '0;
      d.dest_valid    = 1'b0;
      d.fire_link     = 1'b0;
      d.mode = away ? elevator_pkg::FIRE_STOP : elevator_pkg::FIRE_RET;
    end else if (!s.fire_sw && elevator_pkg::in_fire(q.mode)) begin
      d.mode       = elevator_pkg::NORMAL;
      d.fire_link  = 1'b0;
      d.dest_valid = 1'b0;
    end else begin
      unique case (q.mode)
        elevator_pkg::NORMAL: begin
          if (stopped) begin
            d.car_calls[s.car_floor]     = 1'b0;
            d.landing_calls[s.car_floor] = 1'b0;
          end
          // Registration after clearing: a press at the served floor stays.
          if (car_press) begin
            d.car_calls[s.car_btn_floor] = 1'b1;
          end
          if (land_press && land_ok) begin
            d.landing_calls[s.landing_btn_floor] = 1'b1;
            d.landing_accept = 1'b1;
          end
          // The request holds while the car travels, or the drive would stop.
          if (duplex_en && duplex_lead && s.peer_idle &&
              (q.car_idle || (q.run_req && !any_car && !(|q.landing_calls))) &&
              (s.car_floor != wait_floor)) begin
            d.run_req = 1'b1;
            d.target  = wait_floor;
          end
          if (rescue_go) begin
            d.mode = elevator_pkg::RESCUE;
          end else if (s.park_key) begin
            d.mode = elevator_pkg::PARK_RUN;
          end
        end
        elevator_pkg::RESCUE: begin
          if (s.at_level) begin
            d.door_open = 1'b1;
          end else begin
            d.crawl_en = s.safety_ok & s.inv_ok;
            d.crawl_up = s.car_floor < middle_floor;
          end
          if (!s.fault_stop) begin
            d.mode = elevator_pkg::NORMAL;
          end
        end
        elevator_pkg::PARK_RUN: begin
          if (stopped) begin
            d.car_calls[s.car_floor] = 1'b0;
          end
          if (car_press) begin
            d.car_calls[s.car_btn_floor] = 1'b1;
          end
          d.target  = any_car ? first_car : park_floor;
          d.run_req = ~s.inspection &
                      (any_car | (s.car_floor != park_floor));
          if (!s.park_key) begin
            d.mode = elevator_pkg::NORMAL;
          end else if (!any_car && stopped && (s.car_floor == park_floor)) begin
            d.mode = elevator_pkg::PARKED;
          end
        end
        elevator_pkg::PARKED: begin
          d.parking_ind = 1'b1;
          d.display_on  = ~park_exp;
          d.car_light   = ~park_exp | car_press | door_press;
          d.door_open   = ~park_exp;
          d.door_close  = park_exp;
          if (!s.park_key) begin
            d.mode = elevator_pkg::NORMAL;
          end
        end
        elevator_pkg::FIRE_STOP: begin
          d.stop_next  = 1'b1;
          d.door_close = 1'b1;
          if (stopped) begin
            d.mode = elevator_pkg::FIRE_RET;
          end
        end
        elevator_pkg::FIRE_RET: begin
          d.target     = fire_floor;
          d.run_req    = 1'b1;
          d.door_close = 1'b1;
          if (stopped && (s.car_floor == fire_floor)) begin
            d.mode      = elevator_pkg::FIRE_HOLD;
            d.fire_link = 1'b1;
          end
        end
        elevator_pkg::FIRE_HOLD: begin
          d.door_open = 1'b1;
          if (s.fire_mode != `FIRE_MODE_HALT) begin
            if (car_press && !q.dest_valid) begin
              d.dest_valid = 1'b1;
              d.dest       = s.car_btn_floor;
            end
            if (q.dest_valid && s.close_btn) begin
              d.mode = elevator_pkg::FIRE_CLOSE;
            end
          end
        end
        elevator_pkg::FIRE_CLOSE: begin
          d.door_close = 1'b1;
          if (s.door_closed) begin
            d.mode = elevator_pkg::FIRE_RUN;
          end else if (!s.close_btn) begin
            d.mode = elevator_pkg::FIRE_HOLD;
          end
        end
        elevator_pkg::FIRE_RUN: begin
          d.target     = q.dest;
          d.run_req    = 1'b1;
          d.door_close = 1'b1;
          if (stopped && (s.car_floor == q.dest)) begin
            d.mode       = elevator_pkg::FIRE_ARRIVE;
            d.dest_valid = 1'b0;
          end
        end
        elevator_pkg::FIRE_ARRIVE: begin
          d.door_open  = s.open_btn;
          d.door_close = ~s.open_btn;
          if (car_press && !q.dest_valid) begin
            d.dest_valid = 1'b1;
            d.dest       = s.car_btn_floor;
          end
          if (s.open_btn && s.door_open_full) begin
            d.mode = elevator_pkg::FIRE_HOLD;
          end else if (q.dest_valid && s.close_btn && s.door_closed) begin
            d.mode = elevator_pkg::FIRE_CLOSE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q            <= '0;
      q.mode       <= elevator_pkg::NORMAL;
      q.car_light  <= `LIGHT_RST;
      q.display_on <= `DISPLAY_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign target_floor   = q.target;
  assign run_req        = q.run_req;
  assign stop_next      = q.stop_next;
  assign crawl_en       = q.crawl_en;
  assign crawl_up       = q.crawl_up;
  assign door_open_cmd  = q.door_open;
  assign door_close_cmd = q.door_close;
  assign fire_link      = q.fire_link;
  assign parking_ind    = q.parking_ind;
  assign display_on     = q.display_on;
  assign car_light      = q.car_light;
  assign cancel_calls   = q.cancel_calls;
  assign landing_accept = q.landing_accept;
  assign car_calls      = q.car_calls;
  assign landing_calls  = q.landing_calls;
  assign my_cost        = q.my_cost;
  assign car_idle       = q.car_idle;
  assign normal_mode    = (q.mode == elevator_pkg::NORMAL);

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Frozen cycles disable a check, since nothing may move then.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !ce);

  sequence s_reopen;
    (q.mode == elevator_pkg::FIRE_HOLD) ##1 q.door_open;
  endsequence

  property p_fire_entry;
    (s.fire_sw && !elevator_pkg::in_fire(q.mode)) |=>
      q.cancel_calls && (q.car_calls == '0) && (q.landing_calls == '0);
  endproperty
  a_fire_entry: assert property (p_fire_entry)
    else $error("fire entry did not cancel calls");

  property p_link_after_return;
    $rose(q.fire_link) |-> $past(q.mode) == elevator_pkg::FIRE_RET;
  endproperty
  a_link_after_return: assert property (p_link_after_return)
    else $error("fire link raised before return");

  property p_mode1_halt;
    (q.mode == elevator_pkg::FIRE_HOLD) && s.fire_mode && s.fire_sw |=>
      (q.mode == elevator_pkg::FIRE_HOLD) && !q.run_req;
  endproperty
  a_mode1_halt: assert property (p_mode1_halt)
    else $error("car left fire floor in mode 1");

  property p_no_landing_fire;
    elevator_pkg::in_fire(q.mode) |=> !q.landing_accept;
  endproperty
  a_no_landing_fire: assert property (p_no_landing_fire)
    else $error("landing call accepted in fire mode");

  property p_close_release;
    (q.mode == elevator_pkg::FIRE_CLOSE) && !s.close_btn && !s.door_closed &&
      s.fire_sw |=> s_reopen;
  endproperty
  a_close_release: assert property (p_close_release)
    else $error("early release did not reopen door");

  property p_one_dest;
    q.dest_valid && $past(q.dest_valid) |-> $stable(q.dest);
  endproperty
  a_one_dest: assert property (p_one_dest)
    else $error("second destination taken in one run");

  property p_rescue_gate;
    q.crawl_en |-> $past(s.safety_ok && s.inv_ok);
  endproperty
  a_rescue_gate: assert property (p_rescue_gate)
    else $error("rescue crawl without healthy safety and drive");

  property p_park_dark;
    (q.mode == elevator_pkg::PARKED) && park_exp && s.park_key &&
      !s.fire_sw && !car_press && !door_press |=>
      q.parking_ind && !q.car_light && !q.display_on && q.door_close;
  endproperty
  a_park_dark: assert property (p_park_dark)
    else $error("parked car not darkened after timeout");

  property p_unpark;
    (q.mode == elevator_pkg::PARKED) && !s.park_key && !s.fire_sw |=>
      q.mode == elevator_pkg::NORMAL;
  endproperty
  a_unpark: assert property (p_unpark)
    else $error("parking not left when key opened");

endmodule : elevator_mode_supervisor

// File: logic/timeout_timer.sv
// Restartable timeout counted in ticks of the shared time base.
`timescale 1ns/1ps
`include "elevator_regs.svh"

module timeout_timer #(
  parameter int LIMIT = 1000
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic tick,
  input  wire logic restart,
  output logic      expired
);

  elevator_pkg::timer_t q, d;

  always_comb begin
    d = q;
    if (restart) begin
      d.cnt     = '0;
      d.expired = 1'b0;
    end else if (tick && !q.expired) begin
      if (q.cnt == `TMR_W'(LIMIT - 1)) begin
        d.expired = 1'b1;
      end else begin
        d.cnt = q.cnt + `TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign expired = q.expired;

endmodule : timeout_timer

// File: testbench/car_model.sv
// Behavioural car, door operator and drive facing the supervisor.
`timescale 1ns/1ps
`include "elevator_regs.svh"

module car_model (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                run_req,
  input  wire logic [`FLOOR_W-1:0] target_floor,
  input  wire logic                door_open_cmd,
  input  wire logic                door_close_cmd,
  input  wire logic                crawl_en,
  input  wire logic                strand,
  output logic                     moving,
  output logic [`FLOOR_W-1:0]      car_floor,
  output logic                     at_level,
  output logic                     door_closed,
  output logic                     door_open_full
);
  logic [3:0] step_q;
  logic       off_q;
  // The car is off level while travelling or stranded by a fault.
  assign at_level = !off_q && !moving;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_q <= 4'h0;
      off_q <= 1'b0;
      moving <= 1'b0;
      car_floor <= 5'h03;
      door_closed <= 1'b1;
      door_open_full <= 1'b0;
    end else begin
      step_q <= step_q + 4'h1;
      moving <= run_req && (car_floor != target_floor);
      if (moving && step_q == 4'hf) begin
        car_floor <= (target_floor > car_floor) ? car_floor + 5'h01
                                                : car_floor - 5'h01;
      end
      if (strand) begin
        off_q <= 1'b1;
      end else if (crawl_en && step_q == 4'hf) begin
        off_q <= 1'b0;
      end
      if (door_close_cmd) begin
        door_closed <= 1'b1;
        door_open_full <= 1'b0;
      end else if (door_open_cmd) begin
        door_closed <= 1'b0;
        door_open_full <= 1'b1;
      end
    end
  end
endmodule : car_model

// File: testbench/elevator_mode_supervisor_tb_top.sv
// Sequence bench of the mode supervisor driving a behavioural car.
`timescale 1ns/1ps
`include "elevator_regs.svh"

module elevator_mode_supervisor_tb_top;
  localparam int TC = 4;
  localparam int IT = 20;
  localparam int PT = 10;
  logic clk_sys, rst, ce, fire_sw, fire_mode, park_key, inspection, dir_up;
  logic moving, at_level, door_closed, door_open_full, open_btn, close_btn;
  logic fault_stop, safety_ok, inv_ok, car_btn, landing_btn, peer_idle;
  logic duplex_en, duplex_lead, group_en, strand, run_req, stop_next;
  logic crawl_en, crawl_up, door_open_cmd, door_close_cmd, fire_link;
  logic parking_ind, display_on, car_light, cancel_calls, landing_accept;
  logic car_idle, normal_mode;
  logic [`FLOOR_W-1:0] car_btn_floor, landing_btn_floor, car_floor;
  logic [`FLOOR_W-1:0] fire_floor, park_floor, wait_floor, middle_floor;
  logic [`FLOOR_W-1:0] target_floor;
  logic [`COST_W-1:0] peer_cost, my_cost;
  logic [`CAR_IDX_W-1:0] car_index;
  logic [`MAX_CARS-1:0] group_assign;
  logic [`FLOORS-1:0] car_calls, landing_calls;
  int mismatches, compares, acc, cc, cyc, i;

  elevator_mode_supervisor #(.TICK_CYCLES(TC), .IDLE_TICKS(IT),
    .PARK_TICKS(PT)) dut_u (.*);
  car_model car_u (.*);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (landing_accept === 1'b1) acc++;
    if (cancel_calls === 1'b1) cc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic cy(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cy
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Floors settle before the button edge and stay put after it.
  task automatic press(input logic lnd, input logic [`FLOOR_W-1:0] f);
    car_btn_floor = f;
    landing_btn_floor = f;
    cy(3);
    if (lnd) landing_btn = 1'b1;
    else car_btn = 1'b1;
    cy(4);
    landing_btn = 1'b0;
    car_btn = 1'b0;
    cy(4);
  endtask : press
  task automatic results();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    {fire_sw, fire_mode, park_key, inspection, open_btn, close_btn} = '0;
    {fault_stop, car_btn, landing_btn, peer_idle, strand} = '0;
    {duplex_en, duplex_lead, group_en, group_assign, peer_cost} = '0;
    {ce, dir_up, safety_ok, inv_ok, rst} = 5'h1f;
    {car_btn_floor, landing_btn_floor, wait_floor} = '0;
    {fire_floor, park_floor, middle_floor} = {5'h01, 5'h07, 5'h08};
    car_index = 3'h2;
    {mismatches, compares, acc, cc, cyc} = '0;
    cy(16);
    rst = 1'b0;
    cy(2);
    chk(car_light, 1);
    chk(normal_mode, 1);
    cy((IT - 2) * TC);
    chk(car_light, 1);
    cy(4 * TC);
    chk(car_light, 0);
    press(1'b0, 5'h05);
    chk(car_light, 1);
    chk(car_calls[5], 1);
    for (int k = 0; k < 4; k++) begin
      duplex_en = 1'b1;
      group_en = k[1];
      peer_cost = k[0] ? 6'h28 : 6'h02;
      group_assign = k[0] ? 8'h04 : 8'hfb;
      acc = 0;
      press(1'b1, 5'h09);
      chk(acc, k[0]);
    end
    {duplex_en, group_en} = 2'b00;
    fire_mode = 1'b1;
    fire_sw = 1'b1;
    cy(6);
    chk(cc, 1);
    chk(car_calls, 0);
    for (i = 0; i < 400 && fire_link !== 1'b1; i++) cy(1);
    chk(car_floor, fire_floor);
    cy(2);
    chk(door_open_cmd, 1);
    close_btn = 1'b1;
    press(1'b0, 5'h09);
    cy(40);
    chk(run_req | moving, 0);
    {fire_mode, close_btn} = 2'b00;
    acc = 0;
    press(1'b1, 5'h04);
    chk(acc, 0);
    chk(door_open_cmd, 1);
    press(1'b0, 5'h04);
    press(1'b0, 5'h06);
    close_btn = 1'b1;
    cy(3);
    close_btn = 1'b0;
    cy(6);
    chk({door_open_cmd, run_req}, 2'b10);
    close_btn = 1'b1;
    for (i = 0; i < 40 && run_req !== 1'b1; i++) cy(1);
    close_btn = 1'b0;
    chk(target_floor, 5'h04);
    cy(100);
    chk({car_floor, door_open_cmd, door_close_cmd}, 7'h11);
    open_btn = 1'b1;
    cy(5);
    chk(door_open_cmd, 1);
    open_btn = 1'b0;
    fire_sw = 1'b0;
    cy(5);
    chk(fire_link, 0);
    fault_stop = 1'b1;
    safety_ok = 1'b0;
    strand = 1'b1;
    cy(1);
    strand = 1'b0;
    cy(40);
    chk(crawl_en, 0);
    safety_ok = 1'b1;
    cy(5);
    chk({crawl_en, crawl_up}, 2'b11);
    for (i = 0; i < 100 && door_open_cmd !== 1'b1; i++) cy(1);
    chk(at_level, 1);
    fault_stop = 1'b0;
    cy(5);
    park_key = 1'b1;
    for (i = 0; i < 600 && parking_ind !== 1'b1; i++) cy(1);
    chk(car_floor, park_floor);
    for (i = 0; i < 200 && car_light !== 1'b0; i++) cy(1);
    chk(i >= (PT - 1) * TC, 1);
    chk({display_on, door_close_cmd}, 2'b01);
    acc = 0;
    press(1'b1, 5'h02);
    chk(acc, 0);
    open_btn = 1'b1;
    cy(5);
    chk({car_light, door_open_cmd}, 2'b11);
    open_btn = 1'b0;
    cy(PT * TC + 12);
    chk({car_light, door_close_cmd}, 2'b01);
    park_key = 1'b0;
    cy(5);
    chk(normal_mode, 1);
    {duplex_en, duplex_lead, peer_idle, wait_floor} = {3'h7, 5'h0c};
    cy(8);
    chk({run_req, target_floor}, 6'h2c);
    fire_sw = 1'b1;
    cy(4);
    chk({stop_next, door_close_cmd, run_req}, 3'h6);
    for (i = 0; i < 400 && fire_link !== 1'b1; i++) cy(1);
    chk(car_floor, fire_floor);
    results();
  end
endmodule : elevator_mode_supervisor_tb_top
